// ### rtl/hwmon_error_status.sv
// Sticky throttle, input pin and fan error status registers with host access.
//
// Notes on behaviour
// - Any-throttle bit latches on any nonzero throttle in an interval.
// - Bit 1 latches when duty is at least zero and below 12.5 percent.
// - Bit 2 latches when duty is from 12.5 up to 25 percent.
// - Bit 3 latches when duty is from 25 up to 50 percent.
// - Bit 4 latches when duty is from 50 up to 75 percent.
// - Bit 5 latches when duty is from 75 up to 100 percent.
// - Bit 6 latches when the input was active the whole interval.
// - Bit 7 latches when duty exceeds the programmed throttle limit.
// - Only the limit flag of a throttle register feeds the host summary.
// - Fan bits 0 to 3 latch when tach value exceeds limit; 7:4 read zero.
// - The first processor register works alike, its limit flag also summarised.
`timescale 1ns/100ps
`default_nettype none

module hwmon_error_status
   import hwmon_err_pkg::*;
#(
   parameter int TACH_W = 16
) (
   input  wire logic                             clk_sys,
   input  wire logic                             rst,
   input  wire reg_req_t                         reg_req,
   output var  logic [7:0]                       reg_rdata,
   output var  logic                             reg_rvalid,
   input  wire throttle_meas_t                   cpu1_meas,
   input  wire throttle_meas_t                   cpu2_meas,
   input  wire logic [7:0]                       cpu1_throttle_limit,
   input  wire logic [7:0]                       cpu2_throttle_limit,
   input  wire logic [7:0]                       general_pin,
   input  wire logic [7:0]                       input_error_mask,
   input  wire logic [TACH_COUNT-1:0][TACH_W-1:0] tach_value,
   input  wire logic [TACH_COUNT-1:0][TACH_W-1:0] tach_limit,
   output var  logic                             host_error_flag
);

   if (TACH_W < 1 || TACH_W > 16) begin : g_tach_check
      $error("hwmon_error_status TACH_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Throttle interval classification.

   // Turns one completed interval into the set vector of a throttle register.
   function automatic logic [7:0] throttle_set(input throttle_meas_t m,
                                               input logic [7:0]     limit);
      logic [7:0] s;
      s = 8'h00;
      if (m.done) begin
         s[ANY_THROTTLE_BIT]  = m.full || (m.duty != DUTY_ZERO);
         // A full interval reports in its own bit, the any-throttle bit and the limit flag, but in no band.
         s[BAND_0_12_BIT]     = !m.full && (m.duty < DUTY_12_5);
         s[BAND_12_25_BIT]    = !m.full && (m.duty >= DUTY_12_5) && (m.duty < DUTY_25);
         s[BAND_25_50_BIT]    = !m.full && (m.duty >= DUTY_25) && (m.duty < DUTY_50);
         s[BAND_50_75_BIT]    = !m.full && (m.duty >= DUTY_50) && (m.duty < DUTY_75);
         s[BAND_75_100_BIT]   = !m.full && (m.duty >= DUTY_75);
         s[FULL_THROTTLE_BIT] = m.full;
         // Full throttle is above any limit the 8-bit code can express.
         s[LIMIT_FLAG_BIT]    = m.full || (m.duty > limit);
      end
      return s;
   endfunction

   logic [7:0] cpu1_set;
   logic [7:0] cpu2_set;
   logic [7:0] gpi_set;
   logic [7:0] fan_set;

   // Set vectors for the two processor registers.
   always_comb begin
      cpu1_set = throttle_set(cpu1_meas, cpu1_throttle_limit);
      cpu2_set = throttle_set(cpu2_meas, cpu2_throttle_limit);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input pin and fan tachometer conditions.

   // A low pin sets its flag every cycle it stays low, unless masked.
   always_comb begin
      gpi_set = ~general_pin & ~input_error_mask;
   end

   // Tach counts grow as the fan slows, so above the limit means too slow.
   always_comb begin
      fan_set = 8'h00;
      for (int i = 0; i < TACH_COUNT; i++) begin
         fan_set[i] = tach_value[i] > tach_limit[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host write decode: each one in the written byte clears that flag.
   logic [7:0] cpu1_clr;
   logic [7:0] cpu2_clr;
   logic [7:0] gpi_clr;
   logic [7:0] fan_clr;

   always_comb begin
      cpu1_clr = 8'h00;
      cpu2_clr = 8'h00;
      gpi_clr  = 8'h00;
      fan_clr  = 8'h00;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            CPU1_THROTTLE_ERROR_STATUS_ADDR: cpu1_clr = reg_req.wdata;
            CPU2_THROTTLE_ERROR_STATUS_ADDR: cpu2_clr = reg_req.wdata;
            INPUT_PIN_ERROR_STATUS_ADDR:     gpi_clr  = reg_req.wdata;
            FAN_TACH_ERROR_STATUS_ADDR:      fan_clr  = reg_req.wdata & FAN_USED_MASK;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The four sticky registers.
   logic [7:0] cpu1_q;
   logic [7:0] cpu2_q;
   logic [7:0] gpi_q;
   logic [3:0] fan_q;

   sticky_status_reg #(.W(STATUS_W)) u_cpu1 (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (cpu1_set),
      .clr     (cpu1_clr),
      .q       (cpu1_q)
   );

   sticky_status_reg #(.W(STATUS_W)) u_cpu2 (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (cpu2_set),
      .clr     (cpu2_clr),
      .q       (cpu2_q)
   );

   sticky_status_reg #(.W(STATUS_W)) u_gpi (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (gpi_set),
      .clr     (gpi_clr),
      .q       (gpi_q)
   );

   sticky_status_reg #(.W(TACH_COUNT)) u_fan (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (fan_set[TACH_COUNT-1:0]),
      .clr     (fan_clr[TACH_COUNT-1:0]),
      .q       (fan_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read port and host summary.
   logic [7:0] next_rdata;
   logic       next_rvalid;
   logic       next_host_error;

   // Reads return the flags as they stood when the request was taken.
   always_comb begin
      next_rvalid = reg_req.rd;
      next_rdata  = READ_UNMAPPED;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            CPU1_THROTTLE_ERROR_STATUS_ADDR: next_rdata = cpu1_q;
            CPU2_THROTTLE_ERROR_STATUS_ADDR: next_rdata = cpu2_q;
            INPUT_PIN_ERROR_STATUS_ADDR:     next_rdata = gpi_q;
            // Reserved upper nibble reads as zero.
            FAN_TACH_ERROR_STATUS_ADDR:      next_rdata = {4'h0, fan_q};
            default:                         next_rdata = READ_UNMAPPED;
         endcase
      end
   end

   // Band and any-throttle flags are deliberately kept out of the summary.
   always_comb begin
      next_host_error = cpu1_q[LIMIT_FLAG_BIT] || cpu2_q[LIMIT_FLAG_BIT]
                        || (gpi_q != 8'h00) || (fan_q != 4'h0);
   end

   // Output flops; the summary lags the flags by one cycle.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata       <= READ_UNMAPPED;
         reg_rvalid      <= 1'b0;
         host_error_flag <= 1'b0;
      end else begin
         reg_rdata       <= next_rdata;
         reg_rvalid      <= next_rvalid;
         host_error_flag <= next_host_error;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the latching conditions.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence cpu2_done_s;
      cpu2_meas.done && !cpu2_meas.full;
   endsequence

   any_throttle_a: assert property (
      cpu2_meas.done && (cpu2_meas.duty != DUTY_ZERO) |=> cpu2_q[ANY_THROTTLE_BIT])
      else $error("any-throttle flag not latched");

   band_low_a: assert property (
      cpu2_done_s and (cpu2_meas.duty < DUTY_12_5) |=> cpu2_q[BAND_0_12_BIT])
      else $error("lowest band flag not latched");

   band_12_a: assert property (
      cpu2_done_s and (cpu2_meas.duty >= DUTY_12_5 && cpu2_meas.duty < DUTY_25)
      |=> cpu2_q[BAND_12_25_BIT])
      else $error("12.5 to 25 band flag not latched");

   band_25_a: assert property (
      cpu2_done_s and (cpu2_meas.duty >= DUTY_25 && cpu2_meas.duty < DUTY_50)
      |=> cpu2_q[BAND_25_50_BIT])
      else $error("25 to 50 band flag not latched");

   band_50_a: assert property (
      cpu2_done_s and (cpu2_meas.duty >= DUTY_50 && cpu2_meas.duty < DUTY_75)
      |=> cpu2_q[BAND_50_75_BIT])
      else $error("50 to 75 band flag not latched");

   band_75_a: assert property (
      cpu2_done_s and (cpu2_meas.duty >= DUTY_75) |=> cpu2_q[BAND_75_100_BIT])
      else $error("75 to 100 band flag not latched");

   full_throttle_a: assert property (
      cpu2_meas.done && cpu2_meas.full |=> cpu2_q[FULL_THROTTLE_BIT])
      else $error("full throttle flag not latched");

   limit_flag_a: assert property (
      cpu2_meas.done && (cpu2_meas.duty > cpu2_throttle_limit)
      |=> cpu2_q[LIMIT_FLAG_BIT])
      else $error("limit flag not latched");

   no_band_spill_a: assert property (
      !cpu2_meas.done && cpu2_clr == 8'h00 |=> cpu2_q == $past(cpu2_q))
      else $error("throttle flags changed without interval or clear");

   summary_quiet_a: assert property (
      !cpu1_q[LIMIT_FLAG_BIT] && !cpu2_q[LIMIT_FLAG_BIT] && gpi_q == 8'h00
      && fan_q == 4'h0 |=> !host_error_flag)
      else $error("summary raised by a band flag");

   summary_limit_a: assert property (
      $rose(cpu2_q[LIMIT_FLAG_BIT]) |=> host_error_flag)
      else $error("summary missed a limit flag");

   input_low_a: assert property (
      gpi_set != 8'h00 |=> (gpi_q & $past(gpi_set)) == $past(gpi_set))
      else $error("low unmasked pin not latched");

   input_mask_a: assert property (
      1'b1 |=> (gpi_q & ~$past(gpi_q) & $past(input_error_mask | general_pin)) == 8'h00)
      else $error("masked or high pin set its flag");

   fan_over_a: assert property (
      tach_value[0] > tach_limit[0] |=> fan_q[0])
      else $error("fan over-limit flag not latched");

   fan_reserved_a: assert property (
      reg_req.rd && reg_req.addr == FAN_TACH_ERROR_STATUS_ADDR
      |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
      else $error("fan reserved bits not zero");

   cpu1_limit_a: assert property (
      cpu1_meas.done && (cpu1_meas.duty > cpu1_throttle_limit)
      |=> cpu1_q[LIMIT_FLAG_BIT] ##1 host_error_flag)
      else $error("first processor limit not latched or summarised");

   read_back_a: assert property (
      reg_req.rd && reg_req.addr == CPU2_THROTTLE_ERROR_STATUS_ADDR
      |=> reg_rvalid && reg_rdata == $past(cpu2_q))
      else $error("read data differs from held flags");

   // An idle interval must not claim that any throttling happened.
   zero_duty_quiet_a: assert property (
      cpu2_done_s and (cpu2_meas.duty == DUTY_ZERO && !cpu2_q[ANY_THROTTLE_BIT])
      |=> !cpu2_q[ANY_THROTTLE_BIT])
      else $error("any-throttle flag set by an idle interval");

   full_no_band_a: assert property (
      cpu2_meas.done && cpu2_meas.full && !cpu2_q[BAND_75_100_BIT]
      |=> !cpu2_q[BAND_75_100_BIT])
      else $error("full interval spilled into the top band");

   // The limit compare is strict, so a duty equal to the limit stays quiet.
   limit_quiet_a: assert property (
      cpu2_done_s and (cpu2_meas.duty <= cpu2_throttle_limit && !cpu2_q[LIMIT_FLAG_BIT])
      |=> !cpu2_q[LIMIT_FLAG_BIT])
      else $error("limit flag set at or below the limit");

   cpu1_band_a: assert property (
      cpu1_meas.done && !cpu1_meas.full && cpu1_meas.duty >= DUTY_50
      && cpu1_meas.duty < DUTY_75 |=> cpu1_q[BAND_50_75_BIT])
      else $error("first processor band flag not latched");

   // Read data stands for one cycle only and then returns to zero.
   read_idle_a: assert property (
      !reg_req.rd |=> !reg_rvalid && reg_rdata == READ_UNMAPPED)
      else $error("read strobe or data held without a request");

endmodule

`default_nettype wire

// ### rtl/hwmon_err_pkg.sv
// Shared constants and carrier types for the sticky error status registers.
package hwmon_err_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the management register port.
   localparam logic [7:0] CPU1_THROTTLE_ERROR_STATUS_ADDR = 8'h4C;
   localparam logic [7:0] CPU2_THROTTLE_ERROR_STATUS_ADDR = 8'h4D;
   localparam logic [7:0] INPUT_PIN_ERROR_STATUS_ADDR     = 8'h4E;
   localparam logic [7:0] FAN_TACH_ERROR_STATUS_ADDR      = 8'h4F;

   // Width of every status register and its value after reset.
   localparam int         STATUS_W     = 8;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions inside a processor throttle status register.
   localparam int ANY_THROTTLE_BIT  = 0;
   localparam int BAND_0_12_BIT     = 1;
   localparam int BAND_12_25_BIT    = 2;
   localparam int BAND_25_50_BIT    = 3;
   localparam int BAND_50_75_BIT    = 4;
   localparam int BAND_75_100_BIT   = 5;
   localparam int FULL_THROTTLE_BIT = 6;
   localparam int LIMIT_FLAG_BIT    = 7;

   // Duty is n/256 of the interval; band edges at 12.5, 25, 50 and 75 percent.
   localparam logic [7:0] DUTY_ZERO   = 8'h00;
   localparam logic [7:0] DUTY_12_5   = 8'h20;
   localparam logic [7:0] DUTY_25     = 8'h40;
   localparam logic [7:0] DUTY_50     = 8'h80;
   localparam logic [7:0] DUTY_75     = 8'hC0;

   ////////////////////////////////////////////////////////////////////////////
   // Fan register: four tachometer flags in the low bits, 7:4 reserved.
   localparam int         TACH_COUNT    = 4;
   localparam logic [7:0] FAN_USED_MASK = 8'h0F;

   ////////////////////////////////////////////////////////////////////////////
   // One completed throttle monitoring interval.
   typedef struct packed {
      logic       done;  // One-cycle pulse at the end of an interval.
      logic       full;  // Throttle input was active for the whole interval.
      logic [7:0] duty;  // Active time as n/256 of the interval.
   } throttle_meas_t;

   // One register access from the management interface engine.
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// ### rtl/sticky_status_reg.sv
// One sticky status register: hardware sets, a one in a host write clears.
`timescale 1ns/100ps
`default_nettype none

module sticky_status_reg
   import hwmon_err_pkg::*;
#(
   parameter int W = STATUS_W
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output var  logic [W-1:0] q
);

   if (W < 1 || W > STATUS_W) begin : g_width_check
      $error("sticky_status_reg width out of range");
   end

   logic [W-1:0] next_q;

   // A set in the same cycle as its clear wins, so no event is lost.
   always_comb begin
      next_q = (q & ~clr) | set;
   end

   // Flags hold until cleared; reset brings them all to zero.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= W'(STATUS_RESET);
      end else begin
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on holding and clearing.
   sequence no_clear_s;
      clr == '0;
   endsequence

   sequence clear_only_s;
      (clr & ~set) != '0;
   endsequence

   sticky_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      no_clear_s |=> (q & $past(q)) == $past(q))
      else $error("status bit fell without a clear");

   clear_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
      clear_only_s |=> (q & $past(clr & ~set)) == '0)
      else $error("cleared status bit still set");

   set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
      (set & clr) != '0 |=> (q & $past(set)) == $past(set))
      else $error("set lost against a simultaneous clear");

endmodule

`default_nettype wire

// ### verif/mgmt_host_model.sv
// Management host model that reads and write-one-to-clear writes the status registers.
`timescale 1ns/100ps
`default_nettype none

module mgmt_host_model
   import hwmon_err_pkg::*;
(
   input  wire logic       clk_sys,
   output var  reg_req_t   reg_req,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);

   ////////////////////////////////////////////////////////////////////////////
   // The port starts idle; rd and wr stay low until the first access.
   initial begin
      reg_req = '0;
   end

   // One-cycle read pulse; the answer is looked at in the cycle after the taking edge.
   // A released address shows its inverse so no stale value can pass for a live one.
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data,
                           output logic valid);
      @(negedge clk_sys);
      reg_req.rd   = 1'b1;
      reg_req.addr = addr;
      @(posedge clk_sys);
      @(negedge clk_sys);
      valid        = reg_rvalid;
      data         = reg_rdata;
      reg_req.rd   = 1'b0;
      reg_req.addr = ~addr;
   endtask

   // One-cycle write pulse; every one in the data clears that flag.
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] wdata);
      @(negedge clk_sys);
      reg_req.wr    = 1'b1;
      reg_req.addr  = addr;
      reg_req.wdata = wdata;
      @(posedge clk_sys);
      @(negedge clk_sys);
      reg_req.wr    = 1'b0;
      reg_req.addr  = ~addr;
      reg_req.wdata = ~wdata;
   endtask

   // Reads a register, then clears exactly what it saw before trusting new events.
   task automatic read_clear(input logic [7:0] addr, output logic [7:0] data);
      logic valid;
      reg_read(addr, data, valid);
      reg_write(addr, data);
   endtask

endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking testbench for the sticky error status registers.
`timescale 1ns/100ps
`default_nettype none

module testbench
   import hwmon_err_pkg::*;
;
   logic                            clk_sys;
   logic                            rst;
   reg_req_t                        reg_req;
   logic [7:0]                      reg_rdata;
   logic                            reg_rvalid;
   throttle_meas_t                  cpu1_meas;
   throttle_meas_t                  cpu2_meas;
   logic [7:0]                      cpu1_throttle_limit;
   logic [7:0]                      cpu2_throttle_limit;
   logic [7:0]                      general_pin;
   logic [7:0]                      input_error_mask;
   logic [TACH_COUNT-1:0][15:0]     tach_value;
   logic [TACH_COUNT-1:0][15:0]     tach_limit;
   logic                            host_error_flag;
   int                              fail_count;
   int                              n_tests;
   int                              cycles = 0;
   logic [8:0]                      tbl [12];
   logic [7:0]                      e;

   ////////////////////////////////////////////////////////////////////////////
   // Device under test and the host that reaches its registers.
   hwmon_error_status #(.TACH_W(16)) uut (
      .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .cpu1_meas(cpu1_meas), .cpu2_meas(cpu2_meas),
      .cpu1_throttle_limit(cpu1_throttle_limit), .cpu2_throttle_limit(cpu2_throttle_limit),
      .general_pin(general_pin), .input_error_mask(input_error_mask),
      .tach_value(tach_value), .tach_limit(tach_limit), .host_error_flag(host_error_flag)
   );

   mgmt_host_model host (
      .clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
   );

   // Clock of 8 ns period.
   initial begin
      clk_sys = 1'b0;
   end
   always #4 clk_sys = ~clk_sys;

   // Hang guard; the tests need well under a thousand cycles.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count = fail_count + 1;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compares one value and counts the result.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Reads a register and checks both the answer strobe and the data.
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      host.reg_read(addr, d, v);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask

   // One finished monitoring interval, then two cycles so the summary settles.
   task automatic interval(input logic cpu2, input logic [7:0] d, input logic f);
      @(negedge clk_sys);
      if (cpu2) begin
         cpu2_meas = {1'b1, f, d};
      end else begin
         cpu1_meas = {1'b1, f, d};
      end
      @(negedge clk_sys);
      cpu1_meas.done = 1'b0;
      cpu2_meas.done = 1'b0;
      @(negedge clk_sys);
   endtask

   // Flags one completed interval should raise, worked out from the band edges.
   function automatic logic [7:0] exp_thr(input logic [7:0] d, input logic f,
                                          input logic [7:0] lim);
      logic [7:0] r;
      r = 8'h00;
      if (f) begin
         r = 8'hc1;
      end else begin
         r[ANY_THROTTLE_BIT] = (d != DUTY_ZERO);
         if (d < DUTY_12_5) r[BAND_0_12_BIT] = 1'b1;
         else if (d < DUTY_25) r[BAND_12_25_BIT] = 1'b1;
         else if (d < DUTY_50) r[BAND_25_50_BIT] = 1'b1;
         else if (d < DUTY_75) r[BAND_50_75_BIT] = 1'b1;
         else r[BAND_75_100_BIT] = 1'b1;
         r[LIMIT_FLAG_BIT] = (d > lim);
      end
      return r;
   endfunction

   // The single place where the run ends.
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; all inputs change on the falling edge.
   initial begin
      fail_count = 0;
      n_tests = 0;
      rst = 1'b1;
      cpu1_meas = '0;
      cpu2_meas = '0;
      cpu1_throttle_limit = 8'h40;
      cpu2_throttle_limit = 8'h7f;
      general_pin = 8'hff;
      input_error_mask = 8'h0f;
      tach_value = '0;
      tach_limit = {4{16'h1000}};
      tbl = '{9'h000, 9'h001, 9'h01f, 9'h020, 9'h03f, 9'h040,
              9'h07f, 9'h080, 9'h0bf, 9'h0c0, 9'h0ff, 9'h100};
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      for (int a = 0; a < 4; a++) rd_chk(8'h4c + 8'(a), STATUS_RESET);
      rd_chk(8'h50, READ_UNMAPPED);
      // Every band edge, both sides of the strict limit, and a full interval.
      for (int i = 0; i < 12; i++) begin
         e = exp_thr(tbl[i][7:0], tbl[i][8], 8'h7f);
         interval(1'b1, tbl[i][7:0], tbl[i][8]);
         check({7'h00, host_error_flag}, {7'h00, e[LIMIT_FLAG_BIT]});
         rd_chk(CPU2_THROTTLE_ERROR_STATUS_ADDR, e);
         host.reg_write(CPU2_THROTTLE_ERROR_STATUS_ADDR, 8'hff);
      end
      // Flags from two intervals accumulate; a partial clear leaves the rest.
      interval(1'b1, 8'h30, 1'b0);
      interval(1'b1, 8'h00, 1'b0);
      rd_chk(CPU2_THROTTLE_ERROR_STATUS_ADDR, 8'h07);
      host.reg_write(CPU2_THROTTLE_ERROR_STATUS_ADDR, 8'h02);
      rd_chk(CPU2_THROTTLE_ERROR_STATUS_ADDR, 8'h05);
      host.read_clear(CPU2_THROTTLE_ERROR_STATUS_ADDR, e);
      rd_chk(CPU2_THROTTLE_ERROR_STATUS_ADDR, 8'h00);
      // First processor works alike and never touches the second register.
      interval(1'b0, 8'h90, 1'b0);
      check({7'h00, host_error_flag}, 8'h01);
      rd_chk(CPU1_THROTTLE_ERROR_STATUS_ADDR, exp_thr(8'h90, 1'b0, 8'h40));
      rd_chk(CPU2_THROTTLE_ERROR_STATUS_ADDR, 8'h00);
      host.read_clear(CPU1_THROTTLE_ERROR_STATUS_ADDR, e);
      // Pins low for one cycle; the low four are masked.
      general_pin = 8'h00;
      @(negedge clk_sys);
      general_pin = 8'hff;
      rd_chk(INPUT_PIN_ERROR_STATUS_ADDR, 8'hf0);
      host.reg_write(INPUT_PIN_ERROR_STATUS_ADDR, 8'h30);
      rd_chk(INPUT_PIN_ERROR_STATUS_ADDR, 8'hc0);
      // A pin still low while it is cleared keeps its flag.
      general_pin[7] = 1'b0;
      host.reg_write(INPUT_PIN_ERROR_STATUS_ADDR, 8'hff);
      general_pin[7] = 1'b1;
      rd_chk(INPUT_PIN_ERROR_STATUS_ADDR, 8'h80);
      host.read_clear(INPUT_PIN_ERROR_STATUS_ADDR, e);
      rd_chk(INPUT_PIN_ERROR_STATUS_ADDR, 8'h00);
      // Tach above, equal to and below the limit; reserved bits stay zero.
      @(negedge clk_sys);
      tach_value = {16'h1001, 16'h0fff, 16'h1000, 16'hffff};
      @(negedge clk_sys);
      tach_value = '0;
      rd_chk(FAN_TACH_ERROR_STATUS_ADDR, 8'h09);
      host.reg_write(FAN_TACH_ERROR_STATUS_ADDR, 8'hff);
      rd_chk(FAN_TACH_ERROR_STATUS_ADDR, 8'h00);
      repeat (2) @(negedge clk_sys);
      check({7'h00, host_error_flag}, 8'h00);
      report_and_stop();
   end

endmodule
`default_nettype wire
